// file: rtl/aros_clkdiv.sv
// Glitch-free reference divider for one auxiliary output.
`timescale 1ns/1ps
`default_nettype none
module aros_clkdiv (
   // Clock and reset.
   input  wire logic       clk_sys,
   input  wire logic       srst,
   // Sampled reference level and its rising-edge enable.
   input  wire logic       ref_lvl,
   input  wire logic       ref_rise,
   // Requested and active function.
   input  wire logic [1:0] mode_req,
   output logic      [1:0] mode_act_q,
   output logic            clk_div_q
);
   import aros_pkg::*;

   logic [1:0] cnt_q;
   logic       safe;

   // All divided phases are low here, so a switch cannot cut a pulse short.
   assign safe = !ref_lvl && (cnt_q == 2'h0);

   // Counter advances on each reference rising edge; bit 0 is /2 and bit 1 is /4.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         cnt_q <= 2'h0;
      else if (ref_rise)
         cnt_q <= cnt_q + 2'h1;
   end

   // A new function is taken only at a safe point; a stopped-high reference holds it off.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         mode_act_q <= AROS_MODE_OFF;
      else if (mode_req != mode_act_q && safe)
         mode_act_q <= mode_req;
   end

   // Output phase selected by the active function.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         clk_div_q <= 1'b0;
      else
      begin
         unique case (mode_act_q)
            AROS_MODE_OFF:  clk_div_q <= 1'b0;
            AROS_MODE_REF:  clk_div_q <= ref_lvl;
            AROS_MODE_DIV2: clk_div_q <= cnt_q[0];
            AROS_MODE_DIV4: clk_div_q <= cnt_q[1];
         endcase
      end
   end

   switch_safe_a: assert property (@(posedge clk_sys) disable iff (srst)
      !$stable(mode_act_q) |-> $past(safe))
      else $error("Function switched mid-phase.");

   off_low_a: assert property (@(posedge clk_sys) disable iff (srst)
      mode_act_q == AROS_MODE_OFF |=> !clk_div_q)
      else $error("Output high while off.");
endmodule : aros_clkdiv
`default_nettype wire

// file: rtl/aros_pkg.sv
// Constants of the auxiliary clock output block.
`default_nettype none
package aros_pkg;
   // Bus widths of the AXI4-Lite register port.
   localparam int AROS_ADDR_W = 4;
   localparam int AROS_DATA_W = 32;
   // Register byte offsets.
   localparam logic [AROS_ADDR_W-1:0] AROS_OFS_CTRL          = 4'h0;
   localparam logic [AROS_ADDR_W-1:0] AROS_OFS_STATUS        = 4'h4;
   localparam logic [AROS_ADDR_W-1:0] AROS_OFS_SYSREF_PERIOD = 4'h8;
   localparam logic [AROS_ADDR_W-1:0] AROS_OFS_SYSREF_COUNT  = 4'hC;
   // Control register fields and reset value.
   localparam int AROS_CTRL_OVR_BIT    = 0;
   localparam int AROS_CTRL_FIRST_LSB  = 1;
   localparam int AROS_CTRL_SECOND_LSB = 3;
   localparam int AROS_CTRL_ORNG_BIT   = 5;
   localparam int AROS_CTRL_SEL_LSB    = 8;
   localparam logic [AROS_DATA_W-1:0] AROS_CTRL_RESET = 32'h0000_0000;
   // Status register fields.
   localparam int AROS_STAT_STRAP_LSB  = 0;
   localparam int AROS_STAT_PD_BIT     = 2;
   localparam int AROS_STAT_REFSE_BIT  = 3;
   localparam int AROS_STAT_FIRST_LSB  = 4;
   localparam int AROS_STAT_SECOND_LSB = 6;
   localparam int AROS_STAT_PERIOD_BIT = 8;
   localparam int AROS_STAT_SEEN_BIT   = 9;
   // Function codes of straps and mode fields.
   localparam logic [1:0] AROS_MODE_OFF  = 2'h0;
   localparam logic [1:0] AROS_MODE_REF  = 2'h1;
   localparam logic [1:0] AROS_MODE_DIV2 = 2'h2;
   localparam logic [1:0] AROS_MODE_DIV4 = 2'h3;
   // SYSREF sampling taps and measurement widths.
   localparam int AROS_SYSREF_TAPS = 16;
   localparam int AROS_SEL_W       = 4;
   localparam int AROS_PERIOD_W    = 16;
   localparam logic [AROS_PERIOD_W-1:0] AROS_PERIOD_MAX = 16'hFFFF;
   // Number of synchronised pins and the part variant.
   localparam int   AROS_PIN_W        = 8;
   localparam logic AROS_QUAD_CHANNEL = 1'b1;
   // AXI response codes.
   localparam logic [1:0] AROS_RESP_OKAY   = 2'b00;
   localparam logic [1:0] AROS_RESP_SLVERR = 2'b10;
endpackage : aros_pkg
`default_nettype wire

// file: rtl/aros_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module aros_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input  wire logic         clk_sys,
   input  wire logic         srst,
   // Asynchronous pins and their synchronised copy.
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // Only the second stage reads the first, containing metastability.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : aros_sync
`default_nettype wire

// file: rtl/aros_top.sv
// Auxiliary clock outputs, their selection, and SYSREF capture.
//
// How it works
// - Strap-selected clocks run from power-up unprogrammed.
// - Power-down pin high forces both outputs off.
// - First output straps: off, ref, /2, /4.
// - Second output straps: nonzero gives undivided reference.
// - Override bit makes register mode fields win.
// - Clock beats over-range; over-range only on quad.
// - Second clock only while first mode nonzero.
// - SYSREF captured on the device clock edge.
// - Selectable SYSREF sampling instant replaces setup/hold.
// - SYSREF accepted as single pulse or periodic.
// - Reference pin chosen by the single-ended select.
`timescale 1ns/1ps
`default_nettype none
module aros_top (
   // Clock and reset.
   input  wire logic                          clk_sys,
   input  wire logic                          srst,
   // Reference clock inputs and select pin.
   input  wire logic                          diff_clk_in,
   input  wire logic                          single_ended_clk_in,
   input  wire logic                          ref_single_ended_select,
   // Straps, power-down and channel C over-range flag.
   input  wire logic [1:0]                    clk_config_straps,
   input  wire logic                          power_down_pin,
   input  wire logic                          overrange_flag,
   // SYSREF input and captured-edge pulse.
   input  wire logic                          sysref_in,
   output logic                               sysref_capture,
   // Auxiliary CMOS outputs.
   output logic                               aux_out_first,
   output logic                               aux_out_second,
   // AXI4-Lite write address and data channels.
   input  wire logic [aros_pkg::AROS_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [aros_pkg::AROS_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   // AXI4-Lite write response channel.
   output logic      [1:0]                    s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   // AXI4-Lite read channels.
   input  wire logic [aros_pkg::AROS_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic      [aros_pkg::AROS_DATA_W-1:0] s_axi_rdata,
   output logic      [1:0]                    s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready
);
   import aros_pkg::*;

   // Register field under override, else the strap code.
   function automatic logic [1:0] mode_select(input logic ovr, input logic [1:0] strap_code,
                                              input logic [1:0] reg_code);
      mode_select = ovr ? reg_code : strap_code;
   endfunction : mode_select

   logic [AROS_PIN_W-1:0]    pins_s;
   logic                     diff_s, se_s, ref_sel_s, pd_s, orng_s, sysref_s;
   logic [1:0]               straps_s;
   logic                     ref_lvl, ref_prev_q, ref_rise;
   logic [AROS_DATA_W-1:0]   ctrl_q;
   logic                     ctrl_ovr, ctrl_orng;
   logic [1:0]               ctrl_first, ctrl_second;
   logic [AROS_SEL_W-1:0]    ctrl_sel;
   logic [1:0]               first_req, second_strap, second_cand, second_req;
   logic [1:0]               first_act, second_act;
   logic                     first_clk, second_clk;
   logic                     orng_allowed;
   logic [AROS_SYSREF_TAPS-1:0] sr_dly_q;
   logic                     sr_sample, sr_cap_q, sr_evt;
   logic [AROS_PERIOD_W-1:0] per_cnt_q, per_now, period_q, sysref_count_q;
   logic                     periodic_q, seen_q;
   logic [AROS_ADDR_W-1:0]   awaddr_q;
   logic [AROS_DATA_W-1:0]   wdata_q;
   logic [3:0]               wstrb_q;
   logic                     aw_hold_q, w_hold_q, wr_fire;

   // Every pin is asynchronous to clk_sys, so all pass two flops first.
   aros_sync #(.W(AROS_PIN_W)) u_sync (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .async_in ({sysref_in, overrange_flag, power_down_pin, clk_config_straps,
                  ref_single_ended_select, single_ended_clk_in, diff_clk_in}),
      .sync_out (pins_s)
   );

   // Named views of the synchronised pins.
   assign diff_s    = pins_s[0];
   assign se_s      = pins_s[1];
   assign ref_sel_s = pins_s[2];
   assign straps_s  = pins_s[4:3];
   assign pd_s      = pins_s[5];
   assign orng_s    = pins_s[6];
   assign sysref_s  = pins_s[7];

   // Reference source follows the select pin.
   assign ref_lvl  = ref_sel_s ? se_s : diff_s;
   assign ref_rise = ref_lvl && !ref_prev_q;

   // Previous reference level, for edge detection.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         ref_prev_q <= 1'b0;
      else
         ref_prev_q <= ref_lvl;
   end

   // Control register fields.
   assign ctrl_ovr    = ctrl_q[AROS_CTRL_OVR_BIT];
   assign ctrl_first  = ctrl_q[AROS_CTRL_FIRST_LSB +: 2];
   assign ctrl_second = ctrl_q[AROS_CTRL_SECOND_LSB +: 2];
   assign ctrl_orng   = ctrl_q[AROS_CTRL_ORNG_BIT];
   assign ctrl_sel    = ctrl_q[AROS_CTRL_SEL_LSB +: AROS_SEL_W];

   // Straps work with no programming since the control register resets to zero.
   assign first_req    = pd_s ? AROS_MODE_OFF
                              : mode_select(ctrl_ovr, straps_s, ctrl_first);
   assign second_strap = (straps_s != 2'h0) ? AROS_MODE_REF : AROS_MODE_OFF;
   assign second_cand  = mode_select(ctrl_ovr, second_strap, ctrl_second);
   // The second output may carry a clock only behind an enabled first one.
   assign second_req   = (first_req == AROS_MODE_OFF || pd_s) ? AROS_MODE_OFF
                                                              : second_cand;

   // One divider per output.
   aros_clkdiv u_div_first (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .ref_lvl    (ref_lvl),
      .ref_rise   (ref_rise),
      .mode_req   (first_req),
      .mode_act_q (first_act),
      .clk_div_q  (first_clk)
   );

   aros_clkdiv u_div_second (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .ref_lvl    (ref_lvl),
      .ref_rise   (ref_rise),
      .mode_req   (second_req),
      .mode_act_q (second_act),
      .clk_div_q  (second_clk)
   );

   // Over-range exists only on the quad variant.
   assign orng_allowed = ctrl_orng && AROS_QUAD_CHANNEL;

   // Power-down cuts the pins at once, not at a safe point.
   always_ff @(posedge clk_sys)
   begin
      if (srst || pd_s)
      begin
         aux_out_first  <= 1'b0;
         aux_out_second <= 1'b0;
      end
      else
      begin
         aux_out_first  <= (first_act != AROS_MODE_OFF) ? first_clk
                                                        : (orng_allowed && orng_s);
         aux_out_second <= (second_act != AROS_MODE_OFF) ? second_clk
                                                         : (orng_allowed && orng_s);
      end
   end

   // SYSREF delay line; each tap is one sampling instant to choose from.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         sr_dly_q <= '0;
      else
         sr_dly_q <= {sr_dly_q[AROS_SYSREF_TAPS-2:0], sysref_s};
   end

   assign sr_sample = sr_dly_q[ctrl_sel];
   assign sr_evt    = ref_rise && sr_sample && !sr_cap_q;
   assign per_now   = (per_cnt_q == AROS_PERIOD_MAX) ? per_cnt_q : per_cnt_q + 16'h0001;

   // SYSREF is sampled only at device clock rising edges, so latency repeats.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         sr_cap_q       <= 1'b0;
         sysref_capture <= 1'b0;
      end
      else
      begin
         sysref_capture <= sr_evt;
         if (ref_rise)
            sr_cap_q <= sr_sample;
      end
   end

   // Period measurement tells single from periodic SYSREF.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         per_cnt_q      <= '0;
         period_q       <= '0;
         periodic_q     <= 1'b0;
         seen_q         <= 1'b0;
         sysref_count_q <= '0;
      end
      else if (ref_rise)
      begin
         if (sr_evt)
         begin
            per_cnt_q      <= '0;
            period_q       <= per_now;
            periodic_q     <= seen_q && (per_now == period_q);
            seen_q         <= 1'b1;
            sysref_count_q <= sysref_count_q + 16'h0001;
         end
         else
         begin
            per_cnt_q <= per_now;
            if (per_now == AROS_PERIOD_MAX)
               periodic_q <= 1'b0;
         end
      end
   end

   // Write address and data are held apart, then joined.
   assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         aw_hold_q     <= 1'b0;
         s_axi_awready <= 1'b0;
         awaddr_q      <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_hold_q     <= 1'b1;
         s_axi_awready <= 1'b0;
         awaddr_q      <= s_axi_awaddr;
      end
      else if (wr_fire || !aw_hold_q)
      begin
         aw_hold_q     <= 1'b0;
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         w_hold_q     <= 1'b0;
         s_axi_wready <= 1'b0;
         wdata_q      <= '0;
         wstrb_q      <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_hold_q     <= 1'b1;
         s_axi_wready <= 1'b0;
         wdata_q      <= s_axi_wdata;
         wstrb_q      <= s_axi_wstrb;
      end
      else if (wr_fire || !w_hold_q)
      begin
         w_hold_q     <= 1'b0;
         s_axi_wready <= 1'b1;
      end
   end

   // Register update and write response; only the control word is writable.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         ctrl_q       <= AROS_CTRL_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= AROS_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         if (awaddr_q == AROS_OFS_CTRL)
         begin
            s_axi_bresp <= AROS_RESP_OKAY;
            for (int i = 0; i < 4; i++)
               if (wstrb_q[i])
                  ctrl_q[8*i +: 8] <= wdata_q[8*i +: 8];
         end
         else if (awaddr_q == AROS_OFS_STATUS || awaddr_q == AROS_OFS_SYSREF_PERIOD ||
                  awaddr_q == AROS_OFS_SYSREF_COUNT)
            s_axi_bresp <= AROS_RESP_OKAY;
         else
            s_axi_bresp <= AROS_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Read channel; status shows pins and running functions.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= AROS_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= AROS_RESP_OKAY;
         s_axi_rdata   <= '0;
         unique case (s_axi_araddr)
            AROS_OFS_CTRL:          s_axi_rdata <= ctrl_q;
            AROS_OFS_STATUS:
            begin
               s_axi_rdata[AROS_STAT_STRAP_LSB +: 2]  <= straps_s;
               s_axi_rdata[AROS_STAT_PD_BIT]          <= pd_s;
               s_axi_rdata[AROS_STAT_REFSE_BIT]       <= ref_sel_s;
               s_axi_rdata[AROS_STAT_FIRST_LSB +: 2]  <= first_act;
               s_axi_rdata[AROS_STAT_SECOND_LSB +: 2] <= second_act;
               s_axi_rdata[AROS_STAT_PERIOD_BIT]      <= periodic_q;
               s_axi_rdata[AROS_STAT_SEEN_BIT]        <= seen_q;
            end
            AROS_OFS_SYSREF_PERIOD: s_axi_rdata[AROS_PERIOD_W-1:0] <= period_q;
            AROS_OFS_SYSREF_COUNT:  s_axi_rdata[AROS_PERIOD_W-1:0] <= sysref_count_q;
            default:                s_axi_rresp <= AROS_RESP_SLVERR;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

   pd_off_a: assert property (@(posedge clk_sys) disable iff (srst)
      pd_s |=> !aux_out_first && !aux_out_second)
      else $error("Auxiliary output active during power-down.");

   strap_first_a: assert property (@(posedge clk_sys) disable iff (srst)
      !ctrl_ovr && !pd_s |-> first_req == straps_s)
      else $error("First request ignores straps.");

   strap_second_a: assert property (@(posedge clk_sys) disable iff (srst)
      !ctrl_ovr && !pd_s && straps_s != 2'h0 |-> second_req == AROS_MODE_REF)
      else $error("Second strap not the reference.");

   override_a: assert property (@(posedge clk_sys) disable iff (srst)
      ctrl_ovr && !pd_s |-> first_req == ctrl_first &&
         (ctrl_first == AROS_MODE_OFF || second_req == ctrl_second))
      else $error("Override fields not applied.");

   orng_path_a: assert property (@(posedge clk_sys) disable iff (srst)
      !pd_s && first_act == AROS_MODE_OFF && !orng_allowed |=> !aux_out_first)
      else $error("First output driven while unused.");

   second_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
      first_req == AROS_MODE_OFF |-> second_req == AROS_MODE_OFF)
      else $error("Second clock requested without the first.");

   sysref_edge_a: assert property (@(posedge clk_sys) disable iff (srst)
      !$stable(sr_cap_q) |-> $past(ref_rise))
      else $error("SYSREF captured off a clock edge.");

   ref_select_a: assert property (@(posedge clk_sys) disable iff (srst)
      ref_sel_s |-> ref_lvl == se_s)
      else $error("Single-ended reference not selected.");

   bresp_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped early.");
endmodule : aros_top
`default_nettype wire

// file: tb/aros_ref_model.sv
// Far-side model: free-running reference clocks and a SYSREF source.
`timescale 1ns/1ps
`default_nettype none
module aros_ref_model #(
   parameter int SR_DIV = 8
) (
   // Reference clocks toward the block.
   output logic      diff_clk_in,
   output logic      single_ended_clk_in,
   // SYSREF requests from the bench and the SYSREF line.
   input  wire logic sr_periodic,
   input  wire logic sr_single,
   output logic      sysref_in
);
   logic pend;
   // Two references of 8 and 12 system cycles, offset from the system clock.
   initial
   begin
      diff_clk_in = 1'b0;
      #3;
      forever #80 diff_clk_in = ~diff_clk_in;
   end
   initial
   begin
      single_ended_clk_in = 1'b0;
      #7;
      forever #120 single_ended_clk_in = ~single_ended_clk_in;
   end
   // A single request is remembered until the next reference fall.
   initial pend = 1'b0;
   always @(posedge sr_single) pend = 1'b1;
   // SYSREF moves on the reference fall, so the capture edge always sees it settled.
   initial
   begin
      sysref_in = 1'b0;
      forever
      begin
         @(negedge diff_clk_in);
         if (sr_periodic || pend)
         begin
            pend = 1'b0;
            sysref_in = 1'b1;
            repeat (2) @(negedge diff_clk_in);
            sysref_in = 1'b0;
            repeat (SR_DIV - 3) @(negedge diff_clk_in);
         end
      end
   end
endmodule : aros_ref_model
`default_nettype wire

// file: tb/tb.sv
// Bench for the auxiliary clock outputs and SYSREF capture.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import aros_pkg::*;
   typedef struct packed {
      logic [1:0] st;
      logic [2:0] pin;
      logic [7:0] ctrl;
      logic [1:0] e1;
      logic [1:0] e2;
      logic [1:0] lvl;
   } aros_row_t;
   localparam int WIN = 1920;
   logic clk_sys, srst, ref_single_ended_select, power_down_pin, overrange_flag;
   logic diff_clk_in, single_ended_clk_in, sysref_in, sysref_capture, sr_periodic, sr_single;
   logic aux_out_first, aux_out_second, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [1:0]             clk_config_straps, s_axi_bresp, s_axi_rresp, rsp;
   logic [3:0]             s_axi_wstrb;
   logic [AROS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [AROS_DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
   int                     fails = 0, n_compared = 0, n1, n2, c0;
   // Pins are {power down, single-ended select, over-range}; levels are {first, second}.
   aros_row_t rows [14] = '{
      '{2'h1, 3'h0, 8'h00, 2'h1, 2'h1, 2'h0},
      '{2'h2, 3'h0, 8'h00, 2'h2, 2'h1, 2'h0},
      '{2'h3, 3'h0, 8'h00, 2'h3, 2'h1, 2'h0},
      '{2'h0, 3'h1, 8'h00, 2'h0, 2'h0, 2'h0},
      '{2'h0, 3'h1, 8'h20, 2'h0, 2'h0, 2'h3},
      '{2'h2, 3'h1, 8'h20, 2'h2, 2'h1, 2'h0},
      '{2'h3, 3'h5, 8'h20, 2'h0, 2'h0, 2'h0},
      '{2'h1, 3'h2, 8'h00, 2'h1, 2'h1, 2'h0},
      '{2'h2, 3'h2, 8'h00, 2'h2, 2'h1, 2'h0},
      '{2'h1, 3'h0, 8'h1D, 2'h2, 2'h3, 2'h0},
      '{2'h0, 3'h0, 8'h13, 2'h1, 2'h2, 2'h0},
      '{2'h3, 3'h0, 8'h0F, 2'h3, 2'h1, 2'h0},
      '{2'h3, 3'h0, 8'h19, 2'h0, 2'h0, 2'h0},
      '{2'h0, 3'h1, 8'h31, 2'h0, 2'h0, 2'h3}
   };
   aros_top dut (.*);
   aros_ref_model #(.SR_DIV(8)) u_far (.*);
   // A 50 MHz system clock.
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Count a comparison and report a miss at once.
   task automatic chk(input logic ok, input string what);
      n_compared++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask : chk
   // One write; each channel drops once taken, bready stays high.
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok, done;
      {aw_ok, w_ok, done} = 3'h0;
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (int t = 0; t < 100 && !done; t++)
      begin
         @(posedge clk_sys);
         if (aw_ok && w_ok && s_axi_bvalid === 1'b1)
            {done, r} = {1'b1, s_axi_bresp};
         aw_ok |= s_axi_awready === 1'b1;
         w_ok |= s_axi_wready === 1'b1;
         if (aw_ok && !done) s_axi_awvalid <= 1'b0;
         if (w_ok && !done) s_axi_wvalid <= 1'b0;
      end
      if (!done) chk(1'b0, "write got no response");
   endtask : axi_wr
   // One read; rready stays high.
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_ok, done;
      {ar_ok, done} = 2'h0;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (int t = 0; t < 100 && !done; t++)
      begin
         @(posedge clk_sys);
         if (ar_ok && s_axi_rvalid === 1'b1)
            {done, d, r} = {1'b1, s_axi_rdata, s_axi_rresp};
         ar_ok |= s_axi_arready === 1'b1;
         if (ar_ok && !done) s_axi_arvalid <= 1'b0;
      end
      if (!done) chk(1'b0, "read got no data");
   endtask : axi_rd
   // Rising edges on both outputs over a fixed window.
   task automatic measure(output int a, output int b);
      logic p1, p2;
      {a, b, p1, p2} = {32'h0, 32'h0, aux_out_first, aux_out_second};
      repeat (WIN)
      begin
         @(posedge clk_sys);
         a += int'(aux_out_first === 1'b1 && p1 === 1'b0);
         b += int'(aux_out_second === 1'b1 && p2 === 1'b0);
         {p1, p2} = {aux_out_first, aux_out_second};
      end
   endtask : measure
   // Capture pulses seen over a number of cycles.
   task automatic watch(input int cyc, output int n);
      n = 0;
      repeat (cyc)
      begin
         @(posedge clk_sys);
         n += int'(sysref_capture === 1'b1);
      end
   endtask : watch
   // Expected edges per function code and reference period, within one.
   function automatic logic fits(input int n, input logic [1:0] c, input logic se, input logic l,
                                 input logic now);
      int x;
      x = (c == 2'h0) ? 0 : WIN / ((se ? 12 : 8) * ((c == 2'h3) ? 4 : int'(c)));
      return (x == 0) ? (n == 0 && now === l) : (n >= x - 1 && n <= x + 1);
   endfunction : fits
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   // The run takes about 30000 cycles.
   initial
   begin
      repeat (40000) @(posedge clk_sys);
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test();
   end
   initial
   begin
      {srst, power_down_pin, ref_single_ended_select, overrange_flag} = 4'h8;
      {sr_periodic, sr_single, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready, clk_config_straps, s_axi_wstrb} = 8'h1F;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      // The first row runs on straps alone, with nothing programmed.
      for (int i = 0; i < 14; i++)
      begin
         {power_down_pin, ref_single_ended_select, overrange_flag} <= rows[i].pin;
         clk_config_straps <= rows[i].st;
         if (i > 0) axi_wr(AROS_OFS_CTRL, {24'h00_0000, rows[i].ctrl}, rsp);
         repeat (80) @(posedge clk_sys);
         measure(n1, n2);
         chk(fits(n1, rows[i].e1, rows[i].pin[1], rows[i].lvl[1], aux_out_first), "first");
         chk(fits(n2, rows[i].e2, rows[i].pin[1], rows[i].lvl[0], aux_out_second), "second");
         axi_rd(AROS_OFS_STATUS, rd, rsp);
         chk(rd[3:0] === {rows[i].pin[1], rows[i].pin[2], rows[i].st}, "pin status");
         $display("Row %0d done", i);
      end
      // A single SYSREF pulse is captured exactly once.
      {power_down_pin, ref_single_ended_select} <= 2'h0;
      axi_rd(AROS_OFS_SYSREF_COUNT, rd, rsp);
      c0 = int'(rd[15:0]);
      sr_single <= 1'b1;
      watch(400, n1);
      chk(n1 == 1, "single capture count");
      axi_rd(AROS_OFS_SYSREF_COUNT, rd, rsp);
      chk(rd[15:0] === 16'(c0 + 1), "event count");
      $display("Single SYSREF done");
      // Periodic SYSREF through the last sampling tap.
      axi_wr(AROS_OFS_CTRL, 32'h0000_0F00, rsp);
      sr_periodic <= 1'b1;
      watch(640, n1);
      chk(n1 >= 9 && n1 <= 11, "periodic captures");
      axi_rd(AROS_OFS_SYSREF_PERIOD, rd, rsp);
      chk(rd[15:0] === 16'h0008, "period");
      axi_rd(AROS_OFS_STATUS, rd, rsp);
      chk(rd[9:8] === 2'h3, "periodic status");
      sr_periodic <= 1'b0;
      $display("Periodic SYSREF done");
      // Read-only and unmapped places on the register bus.
      axi_wr(AROS_OFS_STATUS, 32'hFFFF_FFFF, rsp);
      chk(rsp === AROS_RESP_OKAY, "status write response");
      axi_wr(4'h2, 32'h0000_0001, rsp);
      chk(rsp === AROS_RESP_SLVERR, "unmapped write");
      axi_rd(4'h2, rd, rsp);
      chk(rsp === AROS_RESP_SLVERR, "unmapped read");
      axi_rd(AROS_OFS_CTRL, rd, rsp);
      chk(rd === 32'h0000_0F00, "control kept");
      $display("Bus cases done");
      // A reset in mid-run returns control to its reset value.
      srst <= 1'b1;
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      axi_rd(AROS_OFS_CTRL, rd, rsp);
      chk(rd === AROS_CTRL_RESET, "control after reset");
      $display("Reset case done");
      stop_test();
   end
endmodule : tb
`default_nettype wire
